// [core/dpsel_core.sv]
`timescale 1ns/100ps
`include "dpsel_cfg.svh"
// What this block does
// - single-ended: pair pins feed refs 0-3; differential: pairs feed refs 0 and 2.
// - four refs get missing-edge, activity and frequency checks; xtal missing-edge only.
// - missing-edge window spans several periods, at least eight measuring clocks.
// - frequency measurement over a nominal 5 ms window.
// - frequency measurement alternatively over a nominal 0.4 s window.
// - loop lock shown as a status bit and, if enabled, on an output pin.
// - loop picks one of the references, automatically or manually.
// - manual index comes from input pins or a configuration field.
// - automatic pick by qualification and priority; ties go to lower index.
// - revertive: always highest-priority qualified ref; equal or lower never displaces.
// - non-revertive: keep current ref until it is disqualified.
// - hitless switching cancels the phase step at switch or holdover exit.
// - controller has six states, entered automatically or by force.
// - reset, VCO calibration or synthesizer mode hold free-run with no ref.
// - any qualified reference (in manual mode only the selected one) moves free-run to acquire with acquisition bandwidth.
// - acquire losing its ref with no other goes to free-run or holdover.
// - acquire goes to normal on lock; normal uses normal bandwidth.
// - normal losing its ref goes to holdover or free-run as configured.
// - switch from normal passes holdover, then hitless switch or acquire.
// - holdover holds instantaneous, filtered or history frequency value.
// - hitless state averages phase offset, stores it, then goes to acquire.
// - write-frequency uses preset offset; force free-run, holdover or write-frequency.
// - lock asserts after phase error stays below threshold for half the interval.
module dpsel_core #(
	parameter int unsigned FWIN_SHORT_CYC = `DPSEL_FWIN_SHORT_CYC,
	parameter int unsigned FWIN_LONG_CYC = `DPSEL_FWIN_LONG_CYC
) (
	input logic clk_sys,
	input logic rst_n,
	input logic ce,
	input logic ref_pair0_true_pin,
	input logic ref_pair0_comp_pin,
	input logic ref_pair1_true_pin,
	input logic ref_pair1_comp_pin,
	input logic xtal_ref_pin,
	input logic input_single_ended,
	input logic [15:0] los_window,
	input logic freq_win_long,
	input logic [3:0][24:0] freq_expect,
	input logic [15:0] freq_tol,
	input logic auto_select,
	input logic revertive,
	input logic manual_from_pins,
	input logic [1:0] general_input_pins,
	input logic [1:0] manual_ref_sel,
	input logic [3:0][3:0] ref_priority,
	input logic synth_mode,
	input logic vco_cal_busy,
	input logic hitless_en,
	input logic loss_to_holdover,
	input logic force_en,
	input logic [1:0] force_state,
	input logic [1:0] holdover_src,
	input logic [28:0] loop_freq_word,
	input logic [28:0] history_freq_word,
	input logic [28:0] write_freq_preset,
	input logic signed [15:0] phase_err,
	input logic [15:0] lock_thr,
	input logic [23:0] lock_interval,
	input logic lock_gpo_en,
	output logic [2:0] dpll_state,
	output logic [1:0] sel_ref,
	output logic sel_ref_valid,
	output logic acq_bw_sel,
	output logic norm_bw_sel,
	output logic lock_status,
	output logic lock_gpo,
	output logic [3:0] ref_qual,
	output logic [3:0] ref_los,
	output logic [3:0] ref_active,
	output logic [3:0] ref_freq_ok,
	output logic xtal_los,
	output logic freq_override,
	output logic [28:0] freq_offset,
	output logic signed [15:0] loop_phase_err,
	output logic signed [15:0] phase_offset
);
	typedef struct packed {
		dpsel_pkg::dpsel_state_t state;
		logic [1:0] sel;
		logic sel_vld;
		logic [3:0] hl_cnt;
		logic signed [19:0] hl_acc;
		logic signed [15:0] ph_off;
		logic signed [15:0] err_adj;
		logic signed [28:0] filt;
		logic [28:0] hold;
		logic [28:0] fout;
	} dpsel_core_st_t;

	dpsel_core_st_t q, d;
	dpsel_mon_if mif();

	logic [3:0] internal_ref;
	logic [3:0] ref_present;
	logic [2:0] best;
	logic [1:0] man_idx;
	logic [1:0] tgt_sel;
	logic tgt_vld, tgt_q, cur_q, new_sel, hard, track;
	logic [28:0] ho_value;
	logic signed [29:0] filt_diff;
	logic signed [19:0] hl_sum;

	function automatic logic [2:0] dpsel_best(input logic [3:0] ok, input logic [3:0][3:0] pr);
		logic [2:0] r;
		r = 3'h0;
		// strict compare: on equal priority the lower index stays
		for (int i = 0; i < 4; i++) begin
			if (ok[i] && (!r[2] || pr[i] < pr[r[1:0]])) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// pin mapping and monitors

	always_comb begin
		internal_ref[0] = ref_pair0_true_pin;
		internal_ref[1] = input_single_ended & ref_pair0_comp_pin;
		internal_ref[2] = ref_pair1_true_pin;
		internal_ref[3] = input_single_ended & ref_pair1_comp_pin;
		ref_present = input_single_ended ? `DPSEL_PRESENT_SE : `DPSEL_PRESENT_DIFF;
	end

	dpsel_ref_monitor #(
		.FWIN_SHORT_CYC(FWIN_SHORT_CYC),
		.FWIN_LONG_CYC(FWIN_LONG_CYC)
	) u_mon (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.ref_lvl(internal_ref),
		.ref_present(ref_present),
		.xtal_lvl(xtal_ref_pin),
		.los_window(los_window),
		.freq_win_long(freq_win_long),
		.freq_expect(freq_expect),
		.freq_tol(freq_tol),
		.mif(mif.mon)
	);

	assign track = (q.state == dpsel_pkg::st_acquire) || (q.state == dpsel_pkg::st_normal);

	dpsel_lock_detect u_lkd (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.track(track),
		.phase_err(phase_err),
		.lock_thr(lock_thr),
		.lock_interval(lock_interval),
		.mif(mif.lkd)
	);

	////////////////////////////////////////////////////////////////
	// reference selection

	always_comb begin
		best = dpsel_best(mif.qual, ref_priority);
		man_idx = manual_from_pins ? general_input_pins : manual_ref_sel;
		cur_q = q.sel_vld & mif.qual[q.sel];
		if (!auto_select) begin
			tgt_sel = man_idx;
			tgt_vld = ref_present[man_idx];
		end else if (!best[2]) begin
			tgt_sel = q.sel;
			tgt_vld = 1'b0;
		end else if (!cur_q) begin
			tgt_sel = best[1:0];
			tgt_vld = 1'b1;
		end else if (revertive && ref_priority[best[1:0]] < ref_priority[q.sel]) begin
			tgt_sel = best[1:0];
			tgt_vld = 1'b1;
		end else begin
			// equal priority or non-revertive: hold on to a healthy ref
			tgt_sel = q.sel;
			tgt_vld = 1'b1;
		end
		tgt_q = tgt_vld & mif.qual[tgt_sel];
		new_sel = tgt_q & (!q.sel_vld || tgt_sel != q.sel);
		hard = synth_mode | vco_cal_busy;
	end

	////////////////////////////////////////////////////////////////
	// loop state machine

	always_comb begin
		d = q;
		case (dpsel_pkg::dpsel_ho_src_t'(holdover_src))
			dpsel_pkg::ho_instant: ho_value = loop_freq_word;
			dpsel_pkg::ho_filtered: ho_value = q.filt;
			default: ho_value = history_freq_word;
		endcase
		filt_diff = 30'(signed'(loop_freq_word)) - 30'(q.filt);
		hl_sum = q.hl_acc + 20'(phase_err);
		if (hard) begin
			d.state = dpsel_pkg::st_free_run;
			d.sel_vld = 1'b0;
		end else if (force_en) begin
			case (dpsel_pkg::dpsel_force_t'(force_state))
				dpsel_pkg::frc_holdover: d.state = dpsel_pkg::st_holdover;
				dpsel_pkg::frc_write_freq: d.state = dpsel_pkg::st_write_freq;
				default: d.state = dpsel_pkg::st_free_run;
			endcase
		end else begin
			case (q.state)
				dpsel_pkg::st_free_run: begin
					if (tgt_q) begin
						d.state = dpsel_pkg::st_acquire;
						d.sel = tgt_sel;
						d.sel_vld = 1'b1;
					end
				end
				dpsel_pkg::st_acquire: begin
					if (!cur_q && !tgt_q) begin
						d.state = loss_to_holdover ? dpsel_pkg::st_holdover : dpsel_pkg::st_free_run;
					end else if (new_sel) begin
						d.sel = tgt_sel;
						d.sel_vld = 1'b1;
					end else if (mif.lock) begin
						d.state = dpsel_pkg::st_normal;
					end
				end
				dpsel_pkg::st_normal: begin
					if (!cur_q && !tgt_q) begin
						d.state = loss_to_holdover ? dpsel_pkg::st_holdover : dpsel_pkg::st_free_run;
					end else if (new_sel) begin
						// park the frequency while the new ref is taken up
						d.state = dpsel_pkg::st_holdover;
						d.sel = tgt_sel;
						d.sel_vld = 1'b1;
					end
				end
				dpsel_pkg::st_holdover: begin
					if (tgt_q) begin
						d.state = hitless_en ? dpsel_pkg::st_hitless : dpsel_pkg::st_acquire;
						d.sel = tgt_sel;
						d.sel_vld = 1'b1;
						d.hl_cnt = 4'h0;
						d.hl_acc = 20'sh0;
					end
				end
				dpsel_pkg::st_hitless: begin
					if (!cur_q) begin
						d.hl_cnt = 4'h0;
						d.hl_acc = 20'sh0;
						if (tgt_q) begin
							d.sel = tgt_sel;
						end else begin
							d.state = loss_to_holdover ? dpsel_pkg::st_holdover : dpsel_pkg::st_free_run;
						end
					end else if (q.hl_cnt == `DPSEL_HL_AVG_LAST) begin
						d.ph_off = 16'(hl_sum >>> `DPSEL_HL_AVG_SHIFT);
						d.state = dpsel_pkg::st_acquire;
					end else begin
						d.hl_acc = hl_sum;
						d.hl_cnt = q.hl_cnt + 4'h1;
					end
				end
				default: begin
					// write-frequency only lives while forced
					d.state = dpsel_pkg::st_free_run;
				end
			endcase
		end
		if (d.state == dpsel_pkg::st_holdover && q.state != dpsel_pkg::st_holdover) begin
			d.hold = ho_value;
		end
		if (track) begin
			d.filt = q.filt + 29'(filt_diff >>> `DPSEL_HO_FILT_SHIFT);
		end
		if (!hitless_en) begin
			d.ph_off = 16'sh0;
		end
		// stored offset cancels the phase step seen by the loop
		d.err_adj = 16'(phase_err - q.ph_off);
		case (q.state)
			dpsel_pkg::st_acquire, dpsel_pkg::st_normal: d.fout = loop_freq_word;
			dpsel_pkg::st_holdover, dpsel_pkg::st_hitless: d.fout = q.hold;
			dpsel_pkg::st_write_freq: d.fout = write_freq_preset;
			default: d.fout = 29'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '{state: dpsel_pkg::st_free_run, default: '0};
		end else if (ce) begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs

	assign dpll_state = q.state;
	assign sel_ref = q.sel;
	assign sel_ref_valid = q.sel_vld;
	assign acq_bw_sel = (q.state == dpsel_pkg::st_acquire);
	assign norm_bw_sel = (q.state == dpsel_pkg::st_normal);
	assign lock_status = mif.lock;
	assign lock_gpo = mif.lock & lock_gpo_en;
	assign ref_qual = mif.qual;
	assign ref_los = mif.loss_of_signal_monitor[3:0];
	assign ref_active = mif.act;
	assign ref_freq_ok = mif.fok;
	assign xtal_los = mif.loss_of_signal_monitor[4];
	assign freq_override = (q.state == dpsel_pkg::st_holdover) || (q.state == dpsel_pkg::st_hitless) ||
		(q.state == dpsel_pkg::st_write_freq);
	assign freq_offset = q.fout;
	assign loop_phase_err = q.err_adj;
	assign phase_offset = q.ph_off;

	hard_free_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && hard |=> q.state == dpsel_pkg::st_free_run && !q.sel_vld)
		else $error("not free-run during calibration or synth mode");
	acq_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !hard && !force_en && q.state == dpsel_pkg::st_acquire && cur_q && !new_sel && mif.lock
		|=> q.state == dpsel_pkg::st_normal)
		else $error("acquire did not move to normal on lock");
	normal_loss_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !hard && !force_en && q.state == dpsel_pkg::st_normal && !cur_q && !tgt_q
		|=> q.state == ($past(loss_to_holdover) ? dpsel_pkg::st_holdover : dpsel_pkg::st_free_run))
		else $error("wrong exit from normal on loss");
	switch_ho_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !hard && !force_en && q.state == dpsel_pkg::st_normal && cur_q && new_sel
		|=> q.state == dpsel_pkg::st_holdover && q.sel == $past(tgt_sel))
		else $error("switch from normal skipped holdover");
	revert_pick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !hard && !force_en && auto_select && revertive && q.state == dpsel_pkg::st_acquire
		&& best[2] && ref_priority[best[1:0]] < ref_priority[q.sel] |=> q.sel == $past(best[1:0]))
		else $error("revertive mode kept a lower priority ref");
	nonrev_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !hard && !force_en && auto_select && !revertive && cur_q && q.state == dpsel_pkg::st_acquire
		|=> $stable(q.sel))
		else $error("non-revertive mode left a qualified ref");
	hitless_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !hard && !force_en && q.state == dpsel_pkg::st_hitless && cur_q && q.hl_cnt == `DPSEL_HL_AVG_LAST
		|=> q.state == dpsel_pkg::st_acquire && (!$past(hitless_en) || q.ph_off == 16'($past(hl_sum) >>> 4)))
		else $error("hitless measurement did not finish into acquire");
	write_freq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && q.state == dpsel_pkg::st_write_freq |=> freq_offset == $past(write_freq_preset))
		else $error("write-frequency did not apply preset");
endmodule

// [common/dpsel_cfg.svh]
`ifndef DPSEL_CFG_SVH
`define DPSEL_CFG_SVH
`define DPSEL_CLK_HZ 50000000
`define DPSEL_CLK_PER_NS 20
`define DPSEL_NREF 4
`define DPSEL_LOS_WIN_MIN 16'h0008
`define DPSEL_FWIN_SHORT_US 5000
`define DPSEL_FWIN_LONG_US 400000
`define DPSEL_FWIN_SHORT_CYC (`DPSEL_FWIN_SHORT_US * (`DPSEL_CLK_HZ / 1000000))
`define DPSEL_FWIN_LONG_CYC (`DPSEL_FWIN_LONG_US * (`DPSEL_CLK_HZ / 1000000))
`define DPSEL_ACT_MIN_EDGES 2'h2
`define DPSEL_HL_AVG_LAST 4'hF
`define DPSEL_HL_AVG_SHIFT 4
`define DPSEL_HO_FILT_SHIFT 4
`define DPSEL_PRESENT_SE 4'hF
`define DPSEL_PRESENT_DIFF 4'h5
`endif

// [common/dpsel_pkg.sv]
package dpsel_pkg;
	typedef enum logic [2:0] {
		st_free_run,
		st_acquire,
		st_normal,
		st_holdover,
		st_hitless,
		st_write_freq
	} dpsel_state_t;

	typedef enum logic [1:0] {
		frc_free_run,
		frc_holdover,
		frc_write_freq
	} dpsel_force_t;

	typedef enum logic [1:0] {
		ho_instant,
		ho_filtered,
		ho_history
	} dpsel_ho_src_t;

	function automatic logic [24:0] dpsel_abs_diff(input logic [24:0] a, input logic [24:0] b);
		return (a > b) ? a - b : b - a;
	endfunction
endpackage

// [common/dpsel_mon_if.sv]
`timescale 1ns/100ps
interface dpsel_mon_if;
	logic [4:0] loss_of_signal_monitor;
	logic [3:0] act;
	logic [3:0] fok;
	logic [3:0] qual;
	logic lock;
	modport mon(output loss_of_signal_monitor, output act, output fok, output qual);
	modport lkd(output lock);
	modport core(input loss_of_signal_monitor, input act, input fok, input qual, input lock);
endinterface

// [core/dpsel_ref_monitor.sv]
`timescale 1ns/100ps
`include "dpsel_cfg.svh"
module dpsel_ref_monitor #(
	parameter int unsigned FWIN_SHORT_CYC = `DPSEL_FWIN_SHORT_CYC,
	parameter int unsigned FWIN_LONG_CYC = `DPSEL_FWIN_LONG_CYC
) (
	input logic clk_sys,
	input logic rst_n,
	input logic ce,
	input logic [3:0] ref_lvl,
	input logic [3:0] ref_present,
	input logic xtal_lvl,
	input logic [15:0] los_window,
	input logic freq_win_long,
	input logic [3:0][24:0] freq_expect,
	input logic [15:0] freq_tol,
	dpsel_mon_if.mon mif
);
	typedef struct packed {
		logic [4:0] prev;
		logic [4:0][15:0] gap;
		logic [4:0] loss_of_signal_monitor;
		logic [15:0] win_cnt;
		logic [3:0][1:0] act_cnt;
		logic [3:0] act;
		logic [24:0] fwin_cnt;
		logic [3:0][24:0] fcnt;
		logic [3:0] fok;
	} dpsel_mon_st_t;

	dpsel_mon_st_t q, d;
	logic [4:0] lvl, rise;
	logic [15:0] win;
	logic [24:0] fend;

	always_comb begin
		d = q;
		lvl = {xtal_lvl, ref_lvl};
		rise = lvl & ~q.prev;
		// a window shorter than this gives a noisy verdict
		win = (los_window < `DPSEL_LOS_WIN_MIN) ? `DPSEL_LOS_WIN_MIN : los_window;
		fend = freq_win_long ? 25'(FWIN_LONG_CYC - 1) : 25'(FWIN_SHORT_CYC - 1);
		d.prev = lvl;
		for (int i = 0; i < 5; i++) begin
			if (rise[i]) begin
				d.gap[i] = 16'h0;
				d.loss_of_signal_monitor[i] = 1'b0;
			end else if (q.gap[i] >= win) begin
				d.loss_of_signal_monitor[i] = 1'b1;
			end else begin
				d.gap[i] = q.gap[i] + 16'h1;
			end
		end
		d.win_cnt = (q.win_cnt >= win - 16'h1) ? 16'h0 : q.win_cnt + 16'h1;
		d.fwin_cnt = (q.fwin_cnt >= fend) ? 25'h0 : q.fwin_cnt + 25'h1;
		// xtal (index 4) only gets the missing-edge check
		for (int i = 0; i < 4; i++) begin
			if (q.win_cnt >= win - 16'h1) begin
				d.act[i] = (q.act_cnt[i] >= `DPSEL_ACT_MIN_EDGES);
				// a rise on the boundary belongs to the next window, not the bin
				d.act_cnt[i] = {1'b0, rise[i]};
			end else if (rise[i] && q.act_cnt[i] != 2'h3) begin
				d.act_cnt[i] = q.act_cnt[i] + 2'h1;
			end
			if (q.fwin_cnt >= fend) begin
				d.fok[i] = dpsel_pkg::dpsel_abs_diff(q.fcnt[i], freq_expect[i]) <= 25'(freq_tol);
				d.fcnt[i] = 25'(rise[i]);
			end else begin
				d.fcnt[i] = q.fcnt[i] + 25'(rise[i]);
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign mif.loss_of_signal_monitor = q.loss_of_signal_monitor;
	assign mif.act = q.act;
	assign mif.fok = q.fok;
	assign mif.qual = ref_present & ~q.loss_of_signal_monitor[3:0] & q.act & q.fok;

	los_window_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !rise[0] && q.gap[0] >= win |=> q.loss_of_signal_monitor[0])
		else $error("missing edges not flagged");
	freq_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && q.fwin_cnt != fend |=> $stable(q.fok))
		else $error("frequency verdict moved inside window");
endmodule

// [core/dpsel_lock_detect.sv]
`timescale 1ns/100ps
module dpsel_lock_detect (
	input logic clk_sys,
	input logic rst_n,
	input logic ce,
	input logic track,
	input logic signed [15:0] phase_err,
	input logic [15:0] lock_thr,
	input logic [23:0] lock_interval,
	dpsel_mon_if.lkd mif
);
	typedef struct packed {
		logic [23:0] cnt;
		logic lock;
	} dpsel_lkd_st_t;

	dpsel_lkd_st_t q, d;
	logic [16:0] mag;
	logic below;

	always_comb begin
		d = q;
		mag = phase_err[15] ? 17'h0 - 17'(phase_err) : 17'(phase_err);
		below = mag < 17'(lock_thr);
		if (!track || !below) begin
			d.cnt = 24'h0;
			d.lock = 1'b0;
		end else if (q.cnt >= (lock_interval >> 1)) begin
			d.lock = 1'b1;
		end else begin
			d.cnt = q.cnt + 24'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign mif.lock = q.lock;

	lock_half_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && track && below && q.cnt >= (lock_interval >> 1) |=> q.lock)
		else $error("lock late after half interval");
endmodule

// [verification/dpsel_ref_src.sv]
`timescale 1ns/100ps
// four reference sources plus the crystal on bit 4
module dpsel_ref_src #(
	parameter int HALF = 4
) (
	input wire logic clk_sys,
	input wire logic [4:0] run,
	output logic [4:0] lvl
);
	int cnt = 0;
	initial lvl = 5'h00;
	// a stopped source freezes its level, as a dead oscillator would
	always @(posedge clk_sys) begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		for (int i = 0; i < 5; i++) begin
			if (run[i] && cnt == HALF - 1) begin
				lvl[i] <= ~lvl[i];
			end
		end
	end
endmodule

// [verification/test_dpll_reference_select_fsm.sv]
`timescale 1ns/100ps
module test_dpll_reference_select_fsm;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [4:0] run = 5'h1B;
	logic [4:0] lvl;
	logic input_single_ended = 1'b1;
	logic [15:0] los_window = 16'h0018;
	logic freq_win_long = 1'b0;
	// period of 8 clocks gives 8 edges in a 64-cycle window
	logic [3:0][24:0] freq_expect = {4{25'h0000008}};
	logic [15:0] freq_tol = 16'h0001;
	logic auto_select = 1'b1;
	logic revertive = 1'b1;
	logic manual_from_pins = 1'b0;
	logic [1:0] general_input_pins = 2'h0;
	logic [1:0] manual_ref_sel = 2'h0;
	// ref2 best; refs 0 and 1 tie so the index decides
	logic [3:0][3:0] ref_priority = {4'h3, 4'h1, 4'h2, 4'h2};
	logic synth_mode = 1'b0;
	logic vco_cal_busy = 1'b0;
	logic hitless_en = 1'b1;
	logic loss_to_holdover = 1'b1;
	logic force_en = 1'b0;
	logic [1:0] force_state = 2'h0;
	logic [1:0] holdover_src = 2'h0;
	logic [28:0] loop_freq_word = 29'h00ABCDE;
	logic [28:0] history_freq_word = 29'h0000000;
	logic [28:0] write_freq_preset = 29'h0000000;
	logic signed [15:0] phase_err = 16'sh0020;
	logic [15:0] lock_thr = 16'h0040;
	logic [23:0] lock_interval = 24'h000010;
	logic lock_gpo_en = 1'b1;
	logic [2:0] dpll_state;
	logic [1:0] sel_ref;
	logic sel_ref_valid;
	logic acq_bw_sel;
	logic norm_bw_sel;
	logic lock_status;
	logic lock_gpo;
	logic [3:0] ref_qual;
	logic [3:0] ref_los;
	logic [3:0] ref_active;
	logic [3:0] ref_freq_ok;
	logic xtal_los;
	logic freq_override;
	logic [28:0] freq_offset;
	logic signed [15:0] loop_phase_err;
	logic signed [15:0] phase_offset;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;

	dpsel_ref_src dpsel_ref_src_i (.clk_sys(clk_sys), .run(run), .lvl(lvl));

	dpsel_core #(.FWIN_SHORT_CYC(64), .FWIN_LONG_CYC(256)) dpsel_core_i (
		.ref_pair0_true_pin(lvl[0]),
		.ref_pair0_comp_pin(lvl[1]),
		.ref_pair1_true_pin(lvl[2]),
		.ref_pair1_comp_pin(lvl[3]),
		.xtal_ref_pin(lvl[4]),
		.*
	);

	always #10 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// bounded waits; a miss shows up in the compare that follows
	task automatic wait_st(input logic [2:0] s);
		for (int n = 0; n < 3000 && dpll_state !== s; n++) @(negedge clk_sys);
	endtask

	task automatic wait_sel(input logic [1:0] r);
		for (int n = 0; n < 3000 && sel_ref !== r; n++) @(negedge clk_sys);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys);
		chk("state", dpll_state, dpsel_pkg::st_free_run);
		chk("valid", sel_ref_valid, 1'b0);
		chk("qual", ref_qual, 4'h0);
		rst_n <= 1'b1;
		$display("test reset done");
		wait_st(dpsel_pkg::st_acquire);
		chk("acquire", dpll_state, dpsel_pkg::st_acquire);
		chk("sel", sel_ref, 2'h0);
		chk("acq_bw", acq_bw_sel, 1'b1);
		chk("los", ref_los, 4'h4);
		chk("active", ref_active, 4'hB);
		chk("freq_ok", ref_freq_ok, 4'hB);
		chk("qual", ref_qual, 4'hB);
		cyc(6);
		chk("early lock", lock_status, 1'b0);
		wait_st(dpsel_pkg::st_normal);
		chk("normal", dpll_state, dpsel_pkg::st_normal);
		chk("norm_bw", norm_bw_sel, 1'b1);
		chk("lock", lock_status, 1'b1);
		chk("lock_gpo", lock_gpo, 1'b1);
		@(posedge clk_sys);
		lock_gpo_en <= 1'b0;
		@(negedge clk_sys);
		chk("gpo off", lock_gpo, 1'b0);
		$display("test auto done");
		// better ref returns: revertive switch through holdover and hitless
		@(posedge clk_sys);
		lock_gpo_en <= 1'b1;
		run <= 5'h1F;
		wait_st(dpsel_pkg::st_holdover);
		chk("sel", sel_ref, 2'h2);
		chk("override", freq_override, 1'b1);
		wait_st(dpsel_pkg::st_hitless);
		chk("hitless", dpll_state, dpsel_pkg::st_hitless);
		wait_st(dpsel_pkg::st_normal);
		chk("sel", sel_ref, 2'h2);
		chk("offset", phase_offset, 32'h00000020);
		chk("loop err", loop_phase_err, 32'h00000000);
		$display("test revertive done");
		@(posedge clk_sys);
		revertive <= 1'b0;
		hitless_en <= 1'b0;
		run <= 5'h1B;
		wait_sel(2'h0);
		chk("sel", sel_ref, 2'h0);
		wait_st(dpsel_pkg::st_normal);
		chk("offset", phase_offset, 32'h00000000);
		@(posedge clk_sys);
		run <= 5'h1F;
		cyc(300);
		chk("qual", ref_qual, 4'hF);
		chk("sel", sel_ref, 2'h0);
		@(posedge clk_sys);
		phase_err <= 16'sh0100;
		cyc(3);
		chk("lock", lock_status, 1'b0);
		$display("test nonrevertive done");
		@(posedge clk_sys);
		phase_err <= 16'sh0020;
		auto_select <= 1'b0;
		manual_from_pins <= 1'b1;
		general_input_pins <= 2'h3;
		wait_sel(2'h3);
		chk("pins sel", sel_ref, 2'h3);
		@(posedge clk_sys);
		manual_from_pins <= 1'b0;
		manual_ref_sel <= 2'h1;
		wait_sel(2'h1);
		chk("field sel", sel_ref, 2'h1);
		chk("valid", sel_ref_valid, 1'b1);
		$display("test manual done");
		// long window needs four times the edge count
		@(posedge clk_sys);
		auto_select <= 1'b1;
		revertive <= 1'b1;
		freq_win_long <= 1'b1;
		freq_expect <= {4{25'h0000020}};
		cyc(600);
		chk("long freq_ok", ref_freq_ok, 4'hF);
		chk("revert sel", sel_ref, 2'h2);
		@(posedge clk_sys);
		run <= 5'h10;
		// sources may stop out of phase, so let every monitor settle first
		cyc(60);
		chk("loss", dpll_state, dpsel_pkg::st_holdover);
		chk("held", freq_offset, 29'h00ABCDE);
		@(posedge clk_sys);
		loop_freq_word <= 29'h0111111;
		cyc(4);
		chk("held", freq_offset, 29'h00ABCDE);
		chk("los", ref_los, 4'hF);
		@(posedge clk_sys);
		run <= 5'h00;
		cyc(40);
		chk("xtal los", xtal_los, 1'b1);
		$display("test loss done");
		@(posedge clk_sys);
		history_freq_word <= 29'h0222222;
		write_freq_preset <= 29'h0333333;
		holdover_src <= 2'h1;
		force_en <= 1'b1;
		force_state <= 2'h0;
		wait_st(dpsel_pkg::st_free_run);
		chk("force free", dpll_state, dpsel_pkg::st_free_run);
		@(posedge clk_sys);
		force_state <= 2'h1;
		wait_st(dpsel_pkg::st_holdover);
		cyc(2);
		// filter settles within one shift step below the tracked word
		chk("filtered", freq_offset >= 29'h00ABCCF && freq_offset <= 29'h00ABCDE, 1'b1);
		@(posedge clk_sys);
		force_state <= 2'h0;
		holdover_src <= 2'h2;
		cyc(2);
		@(posedge clk_sys);
		force_state <= 2'h1;
		wait_st(dpsel_pkg::st_holdover);
		cyc(2);
		chk("history", freq_offset, 29'h0222222);
		@(posedge clk_sys);
		force_state <= 2'h2;
		wait_st(dpsel_pkg::st_write_freq);
		cyc(2);
		chk("preset", freq_offset, 29'h0333333);
		chk("override", freq_override, 1'b1);
		@(posedge clk_sys);
		force_en <= 1'b0;
		cyc(2);
		chk("unforced", dpll_state, dpsel_pkg::st_free_run);
		$display("test force done");
		for (int k = 0; k < 2; k++) begin
			@(posedge clk_sys);
			run <= 5'h1F;
			wait_st(dpsel_pkg::st_acquire);
			@(posedge clk_sys);
			{synth_mode, vco_cal_busy} <= (k == 0) ? 2'h2 : 2'h1;
			cyc(2);
			chk("hold free", dpll_state, dpsel_pkg::st_free_run);
			chk("valid", sel_ref_valid, 1'b0);
			@(posedge clk_sys);
			{synth_mode, vco_cal_busy} <= 2'h0;
		end
		$display("test free-run done");
		@(posedge clk_sys);
		input_single_ended <= 1'b0;
		cyc(300);
		chk("diff qual", ref_qual, 4'h5);
		$display("test differential done");
		final_report();
	end
endmodule
